// >>> ohp_params.svh
`ifndef OHP_PARAMS_SVH
`define OHP_PARAMS_SVH

// System clock period and bus clock period, both in ns
`define OHP_SYS_PERIOD_NS 40
`define OHP_BUS_PERIOD_NS 320
// System cycles per bus clock half period
`define OHP_HALF_CYC ((`OHP_BUS_PERIOD_NS) / (2 * `OHP_SYS_PERIOD_NS))

// Last beat index of the command and address phases
`define OHP_CMD_LAST  8'h01
`define OHP_ADDR_LAST 8'h03

// Reset levels of the link pins
`define OHP_CS_RST     1'b1
`define OHP_CLK_RST    1'b0
`define OHP_CLKC_RST   1'b1
`define OHP_DEVRST_RST 1'b0

`endif

// >>> ohp_pkg.sv
`default_nettype none

package ohp_pkg;

  // Kind of transaction asked for by the user
  typedef enum logic [1:0] {
    KIND_CMD   = 2'h0,
    KIND_REGWR = 2'h1,
    KIND_MEMWR = 2'h2,
    KIND_READ  = 2'h3
  } ohp_kind_e;

  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_CMD   = 7'h02,
    ST_ADDR  = 7'h04,
    ST_LAT   = 7'h08,
    ST_WDATA = 7'h10,
    ST_RDATA = 7'h20,
    ST_END   = 7'h40
  } ohp_state_e;

endpackage

`default_nettype wire

// >>> ohp_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for pins from the device
module ohp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;  // First stage, read only by q

  // Only the second stage is visible to logic
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

`default_nettype wire

// >>> ohp_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "ohp_params.svh"

// Function
// - Select low frames each whole transaction
// - Transfers occur on both bus clock edges
// - Opcode byte sent on both command edges
// - Command always present, address and data optional
// - Clock keeps toggling through read latency
// - Clock keeps toggling through write latency
// - Register writes carry no latency
// - Command, address and bytes go MSB first
// - Lowest addressed byte travels first
// - Dual-die parts always use doubled latency
// - Host does not bound burst length for refresh
// - Three command/address cycles, then latency
// - Host drives strobe as write mask on memory writes only
// - Latency count doubled when strobe high
module ohp_host #(
  parameter int HALF     = `OHP_HALF_CYC,
  parameter int LEN_W    = 8,
  parameter bit DUAL_DIE = 1'b1
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire logic [7:0]         cmd_op,
  input  wire ohp_pkg::ohp_kind_e cmd_kind,
  input  wire logic [31:0]        cmd_addr,
  input  wire logic [LEN_W-1:0]   cmd_len,
  input  wire logic [3:0]         lat_count,
  input  wire logic [15:0]        wr_data,
  input  wire logic [1:0]         wr_mask,
  output logic                    wr_take,
  output logic [15:0]             rd_data,
  output logic                    rd_valid,
  output logic                    done,
  output logic                    refresh_seen,
  output logic                    cs_n,
  output logic                    bus_clk,
  output logic                    bus_clk_comp,
  output logic                    dev_reset_n,
  output logic [7:0]              dq_out,
  output logic                    dq_oe,
  input  wire logic [7:0]         dq_in,
  output logic                    strobe_mask_out,
  output logic                    strobe_mask_oe,
  input  wire logic               strobe_mask_in
);
  import ohp_pkg::*;

  localparam int DW = $clog2(HALF + 1);

  ohp_state_e       st;          // Sequencer state
  ohp_state_e       next_st;     // Its next value
  logic [7:0]       beat;        // Half-period index within a phase
  logic [7:0]       next_beat;   // Its next value
  logic [DW-1:0]    div_cnt;     // Bus clock divider
  ohp_kind_e        kind_q;      // Latched transaction kind
  logic [7:0]       op_q;        // Latched opcode
  logic [31:0]      addr_q;      // Latched word address
  logic [LEN_W-1:0] len_q;       // Latched burst length in words
  logic [3:0]       lat_q;       // Latched latency count
  logic [LEN_W-1:0] tx_words;    // Words sent so far
  logic [LEN_W-1:0] rx_words;    // Words received so far
  logic [7:0]       wlo_q;       // Second byte of current write word
  logic             wmask_lo;    // Its mask bit
  logic             rx_half;     // Expecting second byte of a word
  logic [7:0]       rx_hi;       // First byte of a read word
  logic [7:0]       dq_s;        // Synchronised data pins
  logic             strb_s;      // Synchronised strobe pin
  logic             strb_q;      // Strobe one cycle back

  // Pins from the device cross into clk_sys first
  ohp_sync #(.W(8)) u_sync_dq (.clk_sys(clk_sys), .rst(rst), .d(dq_in), .q(dq_s));
  ohp_sync #(.W(1)) u_sync_strb (.clk_sys(clk_sys), .rst(rst), .d(strobe_mask_in), .q(strb_s));

  // Divider ticks: byte changes mid-half, clock toggles at its end
  wire tick_edge = div_cnt == DW'(HALF - 1);
  wire tick_mid  = div_cnt == DW'(HALF / 2 - 1);
  wire start     = cmd_valid & cmd_ready;
  wire dbl       = refresh_seen | DUAL_DIE;
  wire [7:0] lat_total = 8'({lat_q, 1'b0}) << dbl;
  wire rx_done   = rx_words == len_q;
  // Refresh sample point; the first command half is skipped because the
  // pin sync still holds the level from before the select fell
  wire ca_sample = tick_mid & (st inside {ST_CMD, ST_ADDR}) & ~(st == ST_CMD & beat == 8'h00);
  wire ohp_state_e data_st = (kind_q == KIND_READ) ? ST_RDATA : ST_WDATA;
  // Register writes skip latency; a zero count goes straight to data
  wire ohp_state_e after_addr = (kind_q == KIND_REGWR) ? ST_WDATA :
                                (lat_total == 8'h00) ? data_st : ST_LAT;
  // Clock runs through the frame, parking low once reads are in
  wire in_frame  = st inside {ST_CMD, ST_ADDR, ST_LAT, ST_WDATA, ST_RDATA};
  wire clk_run   = in_frame & ~(st == ST_RDATA & rx_done & ~bus_clk);
  wire [31:0] addr_sh = addr_q << {beat[1:0], 3'b000};
  wire [7:0] tx_byte = (st == ST_CMD) ? op_q :
                       (st == ST_ADDR) ? addr_sh[31:24] :
                       beat[0] ? wlo_q : wr_data[15:8];
  wire drive_dq  = st inside {ST_CMD, ST_ADDR, ST_WDATA};
  wire word_in   = tick_mid & (st == ST_WDATA) & ~beat[0];
  // Strobe edge of the expected polarity: rising then falling per word
  wire rx_edge   = (st == ST_RDATA) & (strb_s != strb_q) & (strb_s == ~rx_half);

  // Sequencer next state, advanced on bus clock edges
  always_comb begin
    next_st   = st;
    next_beat = beat;
    if (st == ST_IDLE) begin
      if (start) begin
        next_st   = ST_CMD;
        next_beat = 8'h00;
      end
    end else if (tick_edge) begin
      next_beat = beat + 8'h01;
      unique case (st)
        ST_IDLE: ;
        ST_CMD: begin
          if (beat == `OHP_CMD_LAST) begin
            next_beat = 8'h00;
            next_st   = (kind_q == KIND_CMD) ? ST_END : ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (beat == `OHP_ADDR_LAST) begin
            next_beat = 8'h00;
            next_st   = after_addr;
          end
        end
        ST_LAT: begin
          if (beat == lat_total - 8'h01) begin
            next_beat = 8'h00;
            next_st   = data_st;
          end
        end
        ST_WDATA: begin
          if (beat[0] && tx_words == len_q - LEN_W'(1)) begin
            next_beat = 8'h00;
            next_st   = ST_END;
          end
        end
        ST_RDATA: begin
          if (rx_done && !bus_clk) begin
            next_beat = 8'h00;
            next_st   = ST_END;
          end
        end
        ST_END: begin
          if (beat[0]) begin
            next_st = ST_IDLE;
          end
        end
        default: next_st = ST_IDLE;
      endcase
    end
  end

  // State, beat and divider
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st      <= ST_IDLE;
      beat    <= 8'h00;
      div_cnt <= '0;
    end else begin
      st      <= next_st;
      beat    <= next_beat;
      div_cnt <= (st == ST_IDLE || tick_edge) ? '0 : div_cnt + DW'(1);
    end
  end

  // Frame pins; the second END half is the select-high gap
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cs_n         <= `OHP_CS_RST;
      bus_clk      <= `OHP_CLK_RST;
      bus_clk_comp <= `OHP_CLKC_RST;
      cmd_ready    <= 1'b0;
      done         <= 1'b0;
      dev_reset_n  <= `OHP_DEVRST_RST;
    end else begin
      cs_n         <= (next_st == ST_IDLE) | (next_st == ST_END & next_beat[0]);
      if (tick_edge && clk_run) begin
        bus_clk      <= ~bus_clk;
        bus_clk_comp <= bus_clk;
      end
      cmd_ready    <= (next_st == ST_IDLE) & (st == ST_IDLE);
      done         <= (st == ST_END) & (next_st == ST_IDLE);
      dev_reset_n  <= 1'b1;
    end
  end

  // Latch a request; burst length is bounded by LEN_W
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      kind_q <= KIND_CMD;
      op_q   <= 8'h00;
      addr_q <= 32'h0000_0000;
      len_q  <= '0;
      lat_q  <= 4'h0;
    end else if (start) begin
      kind_q <= cmd_kind;
      op_q   <= cmd_op;
      addr_q <= cmd_addr;
      len_q  <= (cmd_len == '0) ? LEN_W'(1) : cmd_len;
      lat_q  <= lat_count;
    end
  end

  // Refresh flag sampled mid-half during command and address, sync settled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      refresh_seen <= 1'b0;
    end else if (start) begin
      refresh_seen <= 1'b0;
    end else if (ca_sample && strb_s) begin
      refresh_seen <= 1'b1;
    end
  end

  // Outgoing bytes and mask change half way between clock edges
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dq_out          <= 8'h00;
      dq_oe           <= 1'b0;
      strobe_mask_out <= 1'b0;
      strobe_mask_oe  <= 1'b0;
      wlo_q           <= 8'h00;
      wmask_lo        <= 1'b0;
    end else if (tick_mid) begin
      dq_out          <= drive_dq ? tx_byte : 8'h00;
      dq_oe           <= drive_dq;
      strobe_mask_oe  <= (st == ST_WDATA) & (kind_q == KIND_MEMWR);
      strobe_mask_out <= beat[0] ? wmask_lo : wr_mask[1];
      if (word_in) begin
        wlo_q    <= wr_data[7:0];
        wmask_lo <= wr_mask[0];
      end
    end
  end

  // Write word counting and take pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_words <= '0;
      wr_take  <= 1'b0;
    end else begin
      wr_take <= word_in;
      if (start) begin
        tx_words <= '0;
      end else if (tick_edge && st == ST_WDATA && beat[0]) begin
        tx_words <= tx_words + LEN_W'(1);
      end
    end
  end

  // Read capture on strobe edges; bytes pair into words
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strb_q   <= 1'b0;
      rx_half  <= 1'b0;
      rx_hi    <= 8'h00;
      rx_words <= '0;
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      strb_q   <= strb_s;
      rd_valid <= rx_edge & rx_half & ~rx_done;
      if (start) begin
        rx_half  <= 1'b0;
        rx_words <= '0;
      end else if (rx_edge && !rx_done) begin
        rx_half <= ~rx_half;
        if (!rx_half) begin
          rx_hi <= dq_s;
        end else begin
          rd_data  <= {rx_hi, dq_s};
          rx_words <= rx_words + LEN_W'(1);
        end
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_clk_in_frame: assert property ($changed(bus_clk) |-> !cs_n)
    else $error("bus clock moved outside a frame");
  a_edge_toggles: assert property (tick_edge && clk_run |=> $changed(bus_clk) && bus_clk_comp != bus_clk)
    else $error("clock edge missed");
  a_cmd_first: assert property ($fell(cs_n) |-> st == ST_CMD)
    else $error("frame did not open with a command");
  a_opcode_both: assert property (tick_mid && st == ST_CMD |=> dq_oe && dq_out == op_q)
    else $error("opcode not on command beat");
  a_addr_msb: assert property (tick_mid && st == ST_ADDR && beat == 8'h00 |=> dq_out == addr_q[31:24])
    else $error("address not MSB first");
  a_regwr_nolat: assert property (tick_edge && st == ST_ADDR && beat == 8'h03 && kind_q == KIND_REGWR
                                  |=> st == ST_WDATA)
    else $error("register write got latency");
  a_lat_double: assert property ($rose(st == ST_LAT) |-> lat_total == {2'b00, lat_q, 2'b00} || !DUAL_DIE)
    else $error("latency not doubled");
  a_lat_clock: assert property (st == ST_LAT && tick_edge |=> $changed(bus_clk))
    else $error("clock stopped in latency");
  a_mask_drive: assert property (tick_mid && st == ST_WDATA && kind_q == KIND_MEMWR |=> strobe_mask_oe)
    else $error("mask not driven");
  a_read_float: assert property (tick_mid && st == ST_RDATA |=> !dq_oe && !strobe_mask_oe)
    else $error("host drove pins during read data");
  a_low_first: assert property (word_in |=> dq_out == $past(wr_data[15:8]) ##(HALF) dq_out == wlo_q)
    else $error("byte order wrong");
endmodule

`default_nettype wire

// >>> ohp_dev_model.sv
`timescale 1ns/10ps
`default_nettype none

// Behavioural memory device on the far side of the link
module ohp_dev_model #(
  parameter logic [7:0] OP_RD = 8'hee,
  parameter logic [7:0] OP_MW = 8'hde,
  parameter logic [7:0] OP_RW = 8'h60
) (
  input  wire logic        cs_n,
  input  wire logic        bus_clk,
  input  wire logic        dev_reset_n,
  input  wire logic [7:0]  dq,
  input  wire logic        strobe,
  input  wire logic [3:0]  lat,
  input  wire logic        refresh,
  output logic      [7:0]  dq_o,
  output logic             dq_oe,
  output logic             sm_o,
  output logic             sm_oe,
  output logic      [7:0]  op,
  output logic      [31:0] addr,
  output logic      [15:0] regv,
  output int               beat
);
  logic [15:0] mem [0:15]; // Tiny word array, index wraps
  int          dstart;     // First data beat of the frame
  int          j;          // Data beat index
  logic [3:0]  wa;         // Word in use

  // Nothing driven before the first frame
  initial begin
    dq_oe = 1'b0;
    sm_oe = 1'b0;
  end

  // Frame start: strobe reports pending refresh
  always @(negedge cs_n) begin
    beat = 0;
    sm_oe = dev_reset_n;
    sm_o = refresh;
  end

  // Released lines once deselected or in reset
  always @(posedge cs_n or negedge dev_reset_n) begin
    dq_oe = 1'b0;
    sm_oe = 1'b0;
  end

  // One byte on every clock edge, only inside a frame
  always @(posedge bus_clk or negedge bus_clk) begin
    if (!cs_n && dev_reset_n) begin
      // Dual die: always the doubled count, none for register writes
      dstart = (op == OP_RW) ? 6 : 6 + 4 * lat;
      j = beat - dstart;
      wa = addr[3:0] + 4'(j / 2);
      if (beat < 2) begin
        op = dq;
      end else if (beat < 6) begin
        addr = {addr[23:0], dq};
      end else if (beat >= dstart && op == OP_RW) begin
        regv = {regv[7:0], dq};
      end else if (beat >= dstart && op == OP_MW && !strobe) begin
        if (j[0])
          mem[wa][7:0] = dq;
        else
          mem[wa][15:8] = dq;
      end
      beat = beat + 1;
      // After CA the write mask belongs to the host
      if (beat == 6) begin
        sm_oe = (op == OP_RD);
        sm_o = 1'b0;
      end
      j = beat - dstart;
      wa = addr[3:0] + 4'(j / 2);
      // Strobe and data start together, edge aligned
      if (op == OP_RD && beat >= dstart) begin
        dq_oe = 1'b1;
        sm_o = !j[0];
        dq_o = j[0] ? mem[wa][7:0] : mem[wa][15:8];
      end
    end
  end
endmodule

`default_nettype wire

// >>> octal_ddr_psram_transaction_port_tb.sv
`timescale 1ns/10ps
`default_nettype none

// Host port against the device model, table driven
module octal_ddr_psram_transaction_port_tb;
  import ohp_pkg::*;
  localparam logic [7:0] OP_RD = 8'hee;
  localparam logic [7:0] OP_MW = 8'hde;
  localparam logic [7:0] OP_RW = 8'h60;
  typedef struct {
    ohp_kind_e   kind;
    logic [7:0]  op;
    logic [31:0] addr;
    logic [7:0]  len;
    logic [3:0]  lat;
    logic        rf;
    logic [15:0] d0, d1;
    logic [1:0]  m0;
    logic [15:0] e0, e1;
    int          beats;
  } ohp_row_s;
  ohp_row_s    rows [0:5];
  logic        clk_sys = 1'b0, rst = 1'b1, cmd_valid = 1'b0, rf = 1'b0, tog = 1'b0;
  ohp_kind_e   cmd_kind = KIND_CMD;
  logic [7:0]  cmd_op = 8'h00, cmd_len = 8'h00, dq_out, m_dq, m_op, dq_bus;
  logic [31:0] cmd_addr = 32'h0, m_addr;
  logic [3:0]  lat_count = 4'h0;
  logic [15:0] wdat [0:3] = '{default: 16'h0};
  logic [15:0] rq [0:3];
  logic [15:0] rd_data, m_regv, wr_data;
  logic [1:0]  wmsk = 2'h0, wr_mask;
  logic        cmd_ready, wr_take, rd_valid, done, refresh_seen, cs_n, bus_clk, bus_clk_comp;
  logic        dev_reset_n, dq_oe, strobe_mask_out, strobe_mask_oe, m_dq_oe, m_sm, m_sm_oe, sm_bus;
  int          wi = 0, ri = 0, m_beat, n_fail = 0, comparisons = 0;

  // Undriven lines show a moving pattern, never the last value
  assign dq_bus = dq_oe ? dq_out : m_dq_oe ? m_dq : {8{tog}} ^ 8'h5a;
  assign sm_bus = strobe_mask_oe ? strobe_mask_out : m_sm_oe ? m_sm : tog;
  assign wr_data = wdat[wi[1:0]];
  assign wr_mask = (wi == 0) ? wmsk : 2'h0;

  always #20 clk_sys = ~clk_sys;

  // Pattern toggle, read capture and write word stepping
  always @(posedge clk_sys) begin
    tog <= ~tog;
    if (rd_valid === 1'b1) begin
      rq[ri[1:0]] <= rd_data;
      ri <= ri + 1;
    end
    if (wr_take === 1'b1)
      wi <= wi + 1;
  end

  ohp_host i_dut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .lat_count(lat_count), .wr_data(wr_data), .wr_mask(wr_mask), .wr_take(wr_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .refresh_seen(refresh_seen),
    .cs_n(cs_n), .bus_clk(bus_clk), .bus_clk_comp(bus_clk_comp), .dev_reset_n(dev_reset_n),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_bus), .strobe_mask_out(strobe_mask_out),
    .strobe_mask_oe(strobe_mask_oe), .strobe_mask_in(sm_bus));

  ohp_dev_model #(.OP_RD(OP_RD), .OP_MW(OP_MW), .OP_RW(OP_RW)) i_dev (.cs_n(cs_n),
    .bus_clk(bus_clk), .dev_reset_n(dev_reset_n), .dq(dq_bus), .strobe(sm_bus),
    .lat(lat_count), .refresh(rf), .dq_o(m_dq), .dq_oe(m_dq_oe), .sm_o(m_sm),
    .sm_oe(m_sm_oe), .op(m_op), .addr(m_addr), .regv(m_regv), .beat(m_beat));

  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Single exit of the run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Bounded wait for ready (0) or done (1); a hang ends the run
  task automatic wait_hi(input int sel);
    int k;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while ((sel ? done : cmd_ready) !== 1'b1 && k < 500);
    if ((sel ? done : cmd_ready) !== 1'b1) begin
      chk("handshake wait", 0, 1);
      report_and_stop();
    end
  endtask

  // One whole frame, then its results
  task automatic run_row(input ohp_row_s r);
    @(posedge clk_sys);
    cmd_kind <= r.kind;
    cmd_op <= r.op;
    cmd_addr <= r.addr;
    cmd_len <= r.len;
    lat_count <= r.lat;
    wdat[0] <= r.d0;
    wdat[1] <= r.d1;
    wmsk <= r.m0;
    rf <= r.rf;
    wi <= 0;
    ri <= 0;
    cmd_valid <= 1'b1;
    wait_hi(0);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    wait_hi(1);
    chk("opcode", m_op, r.op);
    if (r.kind != KIND_CMD) chk("address", m_addr, r.addr);
    if (r.kind != KIND_READ) chk("beats", m_beat, r.beats);
    chk("refresh", refresh_seen, r.rf);
    if (r.kind == KIND_READ) chk("words", ri, r.len);
    if (r.kind == KIND_READ) chk("word0", rq[0], r.e0);
    if (r.kind == KIND_READ && r.len > 1) chk("word1", rq[1], r.e1);
    if (r.kind == KIND_REGWR) chk("register", m_regv, r.d0);
    if (r.kind == KIND_MEMWR) chk("taken", wi, r.len);
  endtask

  // Reset, table of frames, then reset inside a frame
  initial begin
    rows[0] = '{KIND_MEMWR, OP_MW, 32'h00000004, 8'h02, 4'h1, 1'b0, 16'h1234, 16'habcd, 2'h0, 16'h0, 16'h0, 14};
    rows[1] = '{KIND_READ, OP_RD, 32'h00000004, 8'h02, 4'h2, 1'b1, 16'h0, 16'h0, 2'h0, 16'h1234, 16'habcd, 0};
    rows[2] = '{KIND_MEMWR, OP_MW, 32'h00000004, 8'h01, 4'h2, 1'b1, 16'h5678, 16'h0, 2'h2, 16'h0, 16'h0, 16};
    rows[3] = '{KIND_READ, OP_RD, 32'h00000004, 8'h01, 4'h1, 1'b0, 16'h0, 16'h0, 2'h0, 16'h1278, 16'h0, 0};
    rows[4] = '{KIND_REGWR, OP_RW, 32'h00000000, 8'h01, 4'h3, 1'b0, 16'hbeef, 16'h0, 2'h0, 16'h0, 16'h0, 8};
    rows[5] = '{KIND_CMD, 8'h66, 32'h00000000, 8'h00, 4'h1, 1'b1, 16'h0, 16'h0, 2'h0, 16'h0, 16'h0, 2};
    repeat (4) @(posedge clk_sys);
    chk("reset pins", {cs_n, bus_clk, bus_clk_comp, dev_reset_n, dq_oe, strobe_mask_oe, cmd_ready}, 7'h50);
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      run_row(rows[i]);
      $display("frame %0d finished", i);
    end
    @(posedge clk_sys);
    cmd_kind <= KIND_READ;
    cmd_valid <= 1'b1;
    wait_hi(0);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("in frame", cs_n, 1'b0);
    rst <= 1'b1;
    @(negedge clk_sys);
    chk("reset mid", {cs_n, dev_reset_n, dq_oe, strobe_mask_oe, m_dq_oe, m_sm_oe}, 6'h20);
    @(posedge clk_sys);
    rst <= 1'b0;
    run_row(rows[5]);
    $display("mid-frame reset finished");
    report_and_stop();
  end
endmodule

`default_nettype wire
